/* File: design/tla_compare.sv */
module tla_compare (
    // stored limits
    tla_limit_if.cmp         lim,
    // current ambient value
    input  wire logic [12:0] amb_temp,
    // raw comparison flags
    output logic      [2:0]  flags
);
    // signed views: limits carry two zero bits at the bottom
    logic signed [12:0] t_amb;
    logic signed [12:0] t_upper;
    logic signed [12:0] t_lower;
    logic signed [12:0] t_crit;

    assign t_amb   = amb_temp;
    assign t_upper = lim.limit[tla_pkg::LIM_UPPER][12:0];
    assign t_lower = lim.limit[tla_pkg::LIM_LOWER][12:0];
    assign t_crit  = lim.limit[tla_pkg::LIM_CRIT][12:0];

    // no config input here: flags ignore event settings
    assign flags[tla_pkg::FLG_CRIT]  = (t_amb >= t_crit);
    assign flags[tla_pkg::FLG_UPPER] = (t_amb > t_upper);
    assign flags[tla_pkg::FLG_LOWER] = (t_amb < t_lower);
endmodule : tla_compare

/* File: design/tla_limit_bank.sv */
module tla_limit_bank (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // host write port
    input  wire logic        wr_en,
    input  wire logic [7:0]  reg_ptr,
    input  wire logic [15:0] wr_data,
    // write protection
    input  wire logic        win_lock,
    input  wire logic        crit_lock,
    // stored limits
    tla_limit_if.bank        lim
);
    genvar i;

    // one storage slot per boundary
    generate
        for (i = 0; i < tla_pkg::LIM_COUNT; i++) begin : g_lim
            logic hit;    // pointer selects this slot
            logic locked; // lock bit for this slot
            assign hit = wr_en && (reg_ptr == tla_pkg::LIM_PTR[i]);
            // critical slot has its own lock
            assign locked = (i == tla_pkg::LIM_CRIT) ? crit_lock : win_lock;

            // masked store: unused bits never hold a one
            always_ff @(posedge sys_clk or negedge resetn) begin
                if (!resetn) begin
                    lim.limit[i] <= tla_pkg::LIM_RESET;
                end else if (hit && !locked) begin
                    lim.limit[i] <= wr_data & tla_pkg::LIM_MASK;
                end
            end
        end
    endgenerate
endmodule : tla_limit_bank

/* File: design/tla_limit_if.sv */
interface tla_limit_if;
    // stored boundaries, in bank slot order
    logic [15:0] limit [0:2];

    // the bank owns the limits
    modport bank (output limit);

    // the comparator and readback only look
    modport cmp (input limit);
endinterface : tla_limit_if

/* File: design/tla_pkg.sv */
package tla_pkg;
    // widths
    localparam int PTR_W  = 8;
    localparam int DATA_W = 16;
    localparam int TEMP_W = 13;
    localparam int LIM_COUNT = 3;

    // register pointer values
    localparam logic [7:0] PTR_UPPER = 8'h02;
    localparam logic [7:0] PTR_LOWER = 8'h03;
    localparam logic [7:0] PTR_CRIT  = 8'h04;
    localparam logic [7:0] PTR_AMB   = 8'h05;

    // limit slots inside the bank
    localparam int LIM_UPPER = 0;
    localparam int LIM_LOWER = 1;
    localparam int LIM_CRIT  = 2;
    localparam logic [7:0] LIM_PTR [0:2] = '{8'h02, 8'h03, 8'h04};

    // field layout
    localparam logic [15:0] LIM_MASK  = 16'h1ffc;
    localparam logic [15:0] LIM_RESET = 16'h0000;
    localparam logic [12:0] AMB_RESET = 13'h0000;
    localparam logic [2:0]  FLG_RESET = 3'h0;
    localparam int FLG_CRIT  = 2;
    localparam int FLG_UPPER = 1;
    localparam int FLG_LOWER = 0;

    // resolution codes
    localparam logic [1:0] RES_HALF    = 2'h0;
    localparam logic [1:0] RES_QUARTER = 2'h1;
    localparam logic [1:0] RES_EIGHTH  = 2'h2;
    localparam logic [1:0] RES_SIXTH   = 2'h3;

    // bits kept at each resolution step
    function automatic logic [12:0] res_mask(input logic [1:0] res);
        case (res)
            RES_HALF:    res_mask = 13'h1ff8;
            RES_QUARTER: res_mask = 13'h1ffc;
            RES_EIGHTH:  res_mask = 13'h1ffe;
            default:     res_mask = 13'h1fff;
        endcase
    endfunction : res_mask
endpackage : tla_pkg

/* File: design/tla_regs.sv */
// Behaviour
// - three 16-bit read/write boundary registers
// - limits at pointers 02, 03, 04
// - limits: signed 11-bit, quarter degree step
// - limit bits 12..2 stored and read back
// - limit bits 15..13, 1..0 read zero
// - enabled event output fires beyond boundaries; with crit_only set, beyond critical only
// - read-only ambient at pointer 05, reset zero
// - ambient temperature double-buffered against reads
// - conversion result loaded in one parallel update
// - bit 15: temperature at or above critical
// - bit 14: temperature strictly above upper
// - bit 13: temperature strictly below lower
// - bits 12..0 signed temperature, bit 12 sign
// - flags computed regardless of event settings
// - bits below resolution step stay zero
// - weights 128 degrees down to one sixteenth
// - two-bit resolution code selects step size
// - locks block writes to guarded limits
module tla_regs (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        resetn,
    // register port from the serial engine
    input  wire logic [7:0]  reg_ptr,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    input  wire logic        rd_en,
    output logic      [15:0] rd_data,
    output logic             rd_valid,
    // converter result
    input  wire logic        conv_valid,
    input  wire logic [12:0] conv_temp,
    // configuration levels
    input  wire logic        event_en,
    input  wire logic        crit_only,
    input  wire logic        win_lock,
    input  wire logic        crit_lock,
    input  wire logic [1:0]  resolution,
    // event output, active high
    output logic             event_out
);

    // ------------------------------------------------
    // internal signals
    // ------------------------------------------------

    // shared limit storage
    tla_limit_if lim_if ();

    // held ambient temperature
    logic [12:0] amb_temp;
    // masked converter word
    logic [12:0] next_amb;
    // comparator outputs
    logic [2:0]  raw_flags;
    // registered flags
    logic [2:0]  flag_q;
    // full ambient word as read
    logic [15:0] amb_word;
    // read mux result
    logic [15:0] next_rd;
    // event level before its flop
    logic        next_event;
    // boundary cause, window or critical
    logic        cause;

    // pointer decode
    logic        sel_upper;
    logic        sel_lower;
    logic        sel_crit;
    logic        sel_amb;

    // ------------------------------------------------
    // limit storage
    // ------------------------------------------------

    // three slots, written through lock gating
    tla_limit_bank u_bank (
        .sys_clk   (sys_clk),
        .resetn    (resetn),
        .wr_en     (wr_en),
        .reg_ptr   (reg_ptr),
        .wr_data   (wr_data),
        .win_lock  (win_lock),
        .crit_lock (crit_lock),
        .lim       (lim_if.bank)
    );

    // ------------------------------------------------
    // comparison
    // ------------------------------------------------

    // flags against the held ambient value
    tla_compare u_cmp (
        .lim      (lim_if.cmp),
        .amb_temp (amb_temp),
        .flags    (raw_flags)
    );

    // ------------------------------------------------
    // ambient capture
    // ------------------------------------------------

    // drop bits finer than the chosen step
    assign next_amb = conv_temp & tla_pkg::res_mask(resolution);

    // one wide load per conversion; reads copy the
    // whole word at once so no half-update is seen
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            amb_temp <= tla_pkg::AMB_RESET;
        end else if (conv_valid) begin
            amb_temp <= next_amb;
        end
    end

    // flags follow both new samples and limit writes
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            flag_q <= tla_pkg::FLG_RESET;
        end else begin
            flag_q <= raw_flags;
        end
    end

    // flags on top, temperature below
    assign amb_word = {flag_q, amb_temp};

    // ------------------------------------------------
    // register readback
    // ------------------------------------------------

    // pointer decode
    assign sel_upper = (reg_ptr == tla_pkg::PTR_UPPER);
    assign sel_lower = (reg_ptr == tla_pkg::PTR_LOWER);
    assign sel_crit  = (reg_ptr == tla_pkg::PTR_CRIT);
    assign sel_amb   = (reg_ptr == tla_pkg::PTR_AMB);

    // unknown pointers read as zero
    assign next_rd =
        sel_upper ? lim_if.limit[tla_pkg::LIM_UPPER] :
        sel_lower ? lim_if.limit[tla_pkg::LIM_LOWER] :
        sel_crit  ? lim_if.limit[tla_pkg::LIM_CRIT]  :
        sel_amb   ? amb_word                         :
                    16'h0000;

    // snapshot on request; held until the next one
    // so both bytes of a read come from one sample
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_data <= 16'h0000;
        end else if (rd_en) begin
            rd_data <= next_rd;
        end
    end

    // one-cycle mark that rd_data is fresh
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
        end
    end

    // ------------------------------------------------
    // event output
    // ------------------------------------------------

    // critical-only mode ignores the window flags
    assign cause = crit_only ? flag_q[tla_pkg::FLG_CRIT] : (|flag_q);

    // comparator style level; pin shaping is elsewhere
    assign next_event = event_en && cause;

    // registered so the pin never glitches
    always_ff @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
            event_out <= 1'b0;
        end else begin
            event_out <= next_event;
        end
    end

    // ------------------------------------------------
    // checks
    // ------------------------------------------------

    // a limit read returns the slot unchanged
    chk_upper_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && sel_upper
        |=> rd_data == $past(lim_if.limit[tla_pkg::LIM_UPPER]))
        else $error("upper limit read mismatch");

    // critical slot sits at its own pointer
    chk_crit_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && sel_crit
        |=> rd_data == $past(lim_if.limit[tla_pkg::LIM_CRIT]))
        else $error("critical limit read mismatch");

    // unused limit bits always read zero
    chk_limit_zero: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && (sel_upper || sel_lower || sel_crit)
        |=> (rd_data & ~tla_pkg::LIM_MASK) == 16'h0000)
        else $error("unused limit bit read as one");

    // an unlocked write lands in the next cycle
    chk_lower_write: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        wr_en && sel_lower && !win_lock
        |=> lim_if.limit[tla_pkg::LIM_LOWER] ==
            ($past(wr_data) & tla_pkg::LIM_MASK))
        else $error("lower limit write lost");

    // window lock freezes upper limit
    chk_window_lock: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        wr_en && sel_upper && win_lock
        |=> $stable(lim_if.limit[tla_pkg::LIM_UPPER]))
        else $error("upper limit changed while locked");

    // critical lock freezes critical limit
    chk_crit_lock: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        wr_en && sel_crit && crit_lock
        |=> $stable(lim_if.limit[tla_pkg::LIM_CRIT]))
        else $error("critical limit changed while locked");

    // ambient ignores host writes
    chk_amb_readonly: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        wr_en && sel_amb && !conv_valid
        |=> $stable(amb_temp))
        else $error("ambient changed on host write");

    // ambient moves only on a conversion
    chk_amb_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !conv_valid |=> $stable(amb_temp))
        else $error("ambient changed without conversion");

    // conversion loads masked word in one step
    chk_amb_load: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        conv_valid
        |=> amb_temp == ($past(conv_temp) &
            tla_pkg::res_mask($past(resolution))))
        else $error("conversion not loaded");

    // quarter step keeps the two low bits clear
    chk_res_quarter: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        conv_valid && resolution == tla_pkg::RES_QUARTER
        |=> amb_temp[1:0] == 2'h0)
        else $error("fraction bits set at quarter step");

    // critical flag read matches signed compare;
    // a read on the first edge out of reset still sees cleared flags
    chk_crit_flag: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && sel_amb && $past(resetn)
        |=> rd_data[15] == ($signed($past(amb_temp, 2)) >=
            $signed($past(lim_if.limit[tla_pkg::LIM_CRIT][12:0], 2))))
        else $error("critical flag wrong");

    // upper flag is strict: equal reads zero
    chk_upper_flag: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && sel_amb
        |=> rd_data[14] == ($signed($past(amb_temp, 2)) >
            $signed($past(lim_if.limit[tla_pkg::LIM_UPPER][12:0], 2))))
        else $error("upper flag read wrong");

    // lower flag read in bit 13, strict as well
    chk_lower_flag: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && sel_amb
        |=> rd_data[13] == ($signed($past(amb_temp, 2)) <
            $signed($past(lim_if.limit[tla_pkg::LIM_LOWER][12:0], 2))))
        else $error("lower flag read wrong");

    // flags present even with event disabled
    chk_flag_free: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !event_en
        |=> flag_q == {($signed($past(amb_temp)) >=
                        $signed($past(lim_if.limit[tla_pkg::LIM_CRIT][12:0]))),
                       ($signed($past(amb_temp)) >
                        $signed($past(lim_if.limit[tla_pkg::LIM_UPPER][12:0]))),
                       ($signed($past(amb_temp)) <
                        $signed($past(lim_if.limit[tla_pkg::LIM_LOWER][12:0])))})
        else $error("flags gated by event setting");

    // disabled event output stays low
    chk_event_off: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !event_en |=> !event_out)
        else $error("event asserted while disabled");

    // critical crossing raises the event
    chk_event_crit: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        event_en && flag_q[tla_pkg::FLG_CRIT] |=> event_out)
        else $error("event missed on critical");

    // lower slot sits at its own pointer
    chk_lower_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && sel_lower
        |=> rd_data == $past(lim_if.limit[tla_pkg::LIM_LOWER]))
        else $error("lower limit read mismatch");

    // an unlocked upper write lands masked
    chk_upper_write: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        wr_en && sel_upper && !win_lock
        |=> lim_if.limit[tla_pkg::LIM_UPPER] ==
            ($past(wr_data) & tla_pkg::LIM_MASK))
        else $error("upper limit write lost");

    // ambient read carries the held temperature
    chk_amb_read: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en && sel_amb
        |=> rd_data[12:0] == $past(amb_temp))
        else $error("ambient temperature read wrong");

    // snapshot holds while no read is asked for
    chk_rd_hold: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !rd_en |=> $stable(rd_data))
        else $error("read data moved without a read");

    // every read is answered one edge later
    chk_rd_pulse: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        rd_en |=> rd_valid)
        else $error("read not answered");

    // window crossing raises the event unless critical-only
    chk_event_window: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        event_en && !crit_only &&
        (flag_q[tla_pkg::FLG_UPPER] || flag_q[tla_pkg::FLG_LOWER])
        |=> event_out)
        else $error("event missed on window");

    // no boundary crossed, no event
    chk_event_quiet: assert property (
        @(posedge sys_clk) disable iff (!resetn)
        !flag_q[tla_pkg::FLG_CRIT] &&
        (crit_only || !(flag_q[tla_pkg::FLG_UPPER] || flag_q[tla_pkg::FLG_LOWER]))
        |=> !event_out)
        else $error("event without a crossing");

endmodule : tla_regs

/* File: verification/temp_limit_ambient_regs_tb_top.sv */
module temp_limit_ambient_regs_tb_top;
    timeunit 1ns;
    timeprecision 100ps;

    logic        sys_clk, resetn, conv_valid, event_en, crit_only;
    logic        win_lock, crit_lock, wr_en, rd_en, rd_valid, event_out;
    logic [7:0]  reg_ptr;
    logic [15:0] wr_data, rd_data;
    logic [12:0] conv_temp;
    logic [1:0]  resolution;
    int          error_cnt, n_tests, cyc;
    logic [15:0] m_lim [3]; // reference limits
    logic [12:0] m_amb;     // reference ambient
    logic [12:0] tlist [9]; // awkward temperatures

    tla_regs dut (.sys_clk(sys_clk), .resetn(resetn), .reg_ptr(reg_ptr), .wr_en(wr_en),
        .wr_data(wr_data), .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid),
        .conv_valid(conv_valid), .conv_temp(conv_temp), .event_en(event_en),
        .crit_only(crit_only), .win_lock(win_lock), .crit_lock(crit_lock),
        .resolution(resolution), .event_out(event_out));
    tla_host host (.sys_clk(sys_clk), .reg_ptr(reg_ptr), .wr_en(wr_en), .wr_data(wr_data),
        .rd_en(rd_en), .rd_data(rd_data), .rd_valid(rd_valid));

    // 200 MHz clock
    always #2.5 sys_clk = ~sys_clk;

    // hang guard, far above the few hundred cycles needed
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            give_verdict();
        end
    end

    // one compare for words, one for single bits
    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t word got %h expected %h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bit(input logic got, input logic exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %0t bit got %b expected %b", $time, got, exp);
        end
    endtask : chk_bit

    // reference ambient word with its three flags
    function automatic logic [15:0] amb_word();
        logic c, u, l;
        c = $signed(m_amb) >= $signed(m_lim[2][12:0]);
        u = $signed(m_amb) > $signed(m_lim[0][12:0]);
        l = $signed(m_amb) < $signed(m_lim[1][12:0]);
        return {c, u, l, m_amb};
    endfunction : amb_word

    // write through the host, mirrored in the reference
    task automatic do_wr(input logic [7:0] p, input logic [15:0] d);
        host.wr(p, d);
        if ((p == 8'h02 || p == 8'h03) && !win_lock) m_lim[p - 2] = d & tla_pkg::LIM_MASK;
        if (p == 8'h04 && !crit_lock) m_lim[2] = d & tla_pkg::LIM_MASK;
    endtask : do_wr

    // read through the host and compare with the reference
    task automatic do_rd(input logic [7:0] p);
        logic [15:0] e;
        e = 16'h0000;
        if (p >= 8'h02 && p <= 8'h04) e = m_lim[p - 2];
        if (p == 8'h05) e = amb_word();
        host.rd(p);
        chk_word(host.last_rd, e);
        chk_bit(host.last_ok, 1'b1);
    endtask : do_rd

    // async reset, reference cleared alongside
    task automatic do_reset();
        resetn = 1'b0;
        repeat (8) @(posedge sys_clk);
        #1;
        resetn = 1'b1;
        m_lim = '{16'h0000, 16'h0000, 16'h0000};
        m_amb = 13'h0000;
    endtask : do_reset

    // pointers 00 to 08 and ff, mapped or not, straight after reset
    task automatic rd_all();
        foreach (tlist[i]) do_rd(8'(i));
        do_rd(8'hff);
        $display("test reset readback done");
    endtask : rd_all

    // one conversion, then the event level three edges on
    task automatic do_conv(input logic [12:0] t);
        logic [15:0] w;
        @(posedge sys_clk);
        #1;
        conv_valid = 1'b1;
        conv_temp  = t;
        @(posedge sys_clk);
        #1;
        conv_valid = 1'b0;
        conv_temp  = ~t;
        // low bits below the step are dropped at capture
        m_amb = t & ~13'((1 << (3 - resolution)) - 1);
        w = amb_word();
        repeat (2) @(posedge sys_clk);
        #1;
        chk_bit(event_out, event_en & (crit_only ? w[15] : |w[15:13]));
        do_rd(8'h05);
    endtask : do_conv

    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        sys_clk = 1'b0;
        resetn = 1'b0;
        conv_valid = 1'b0;
        conv_temp = 13'h0000;
        event_en = 1'b0;
        crit_only = 1'b0;
        win_lock = 1'b0;
        crit_lock = 1'b0;
        resolution = 2'h1;
        error_cnt = 0;
        n_tests = 0;
        cyc = 0;
        void'($urandom(55));
        do_reset();
        rd_all();
        // random limits, unused bits set on purpose
        repeat (12) begin
            do_wr(8'(2 + $urandom % 3), 16'($urandom));
            for (int p = 2; p < 5; p++) do_rd(8'(p));
        end
        do_wr(8'h05, 16'hffff);
        do_wr(8'h07, 16'h1234);
        do_rd(8'h05);
        do_rd(8'h07);
        $display("test limit storage done");
        // every lock combination against every limit
        for (int lk = 0; lk < 4; lk++) begin
            @(posedge sys_clk);
            #1;
            {win_lock, crit_lock} = 2'(lk);
            for (int p = 2; p < 5; p++) begin
                do_wr(8'(p), 16'($urandom));
                do_rd(8'(p));
            end
        end
        win_lock = 1'b0;
        crit_lock = 1'b0;
        $display("test locks done");
        // 25, -8 and 80 degree boundaries
        do_wr(8'h02, 16'h0190);
        do_wr(8'h03, 16'h1f80);
        do_wr(8'h04, 16'h0500);
        tlist = '{13'h0190, 13'h0194, 13'h018c, 13'h1f80, 13'h1f7c, 13'h1f84,
                  13'h0500, 13'h04fc, 13'h1fff};
        repeat (48) begin
            @(posedge sys_clk);
            #1;
            resolution = 2'($urandom);
            event_en = 1'($urandom);
            crit_only = 1'($urandom);
            do_conv(($urandom % 2) ? tlist[$urandom % 9] : 13'($urandom));
        end
        $display("test conversions done");
        // second reset in mid-run
        do_reset();
        rd_all();
        give_verdict();
    end
endmodule : temp_limit_ambient_regs_tb_top

/* File: verification/tla_host.sv */
module tla_host (
    // clock
    input  wire logic        sys_clk,
    // register port requests
    output logic      [7:0]  reg_ptr,
    output logic             wr_en,
    output logic      [15:0] wr_data,
    output logic             rd_en,
    // register port answers
    input  wire logic [15:0] rd_data,
    input  wire logic        rd_valid
);
    timeunit 1ns;
    timeprecision 100ps;

    logic [15:0] last_rd; // word taken with the answer
    logic        last_ok; // answer strobe seen with it

    // idle bus at time zero
    initial begin
        reg_ptr = 8'h00;
        wr_en   = 1'b0;
        wr_data = 16'h0000;
        rd_en   = 1'b0;
    end

    // one write, held across its taking edge
    task automatic wr(input logic [7:0] p, input logic [15:0] d);
        @(posedge sys_clk);
        #1;
        reg_ptr = p;
        wr_data = d;
        wr_en   = 1'b1;
        @(posedge sys_clk);
        #1;
        wr_en   = 1'b0;
        // released lines must not keep the last value
        reg_ptr = ~p;
        wr_data = ~d;
    endtask : wr

    // one read; answer is registered on the taking edge and sampled 1 ns later
    task automatic rd(input logic [7:0] p);
        @(posedge sys_clk);
        #1;
        reg_ptr = p;
        rd_en   = 1'b1;
        @(posedge sys_clk);
        #1;
        last_rd = rd_data;
        last_ok = rd_valid;
        rd_en   = 1'b0;
        reg_ptr = ~p;
    endtask : rd
endmodule : tla_host
